// ==== pdc_consts.svh ====
// timing counts, frame field positions, register offsets and reset values of the synthesizer control
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH

`define PDC_CLK_MHZ          100
`define PDC_WAKE_TIME_NS     2000
`define PDC_WAKE_CYCLES      ((`PDC_WAKE_TIME_NS * `PDC_CLK_MHZ) / 1000)
`define PDC_ERR_LIMIT        8'h04
`define PDC_LOCK_WIN         8'h02
`define PDC_LOCK_COUNT       8'h08

`define PDC_FRAME_W          19
`define PDC_REF_FRAME_BITS   5'h12
`define PDC_DIV_FRAME_BITS   5'h13
`define PDC_REF_LATCH_W      17
`define PDC_DIV_LATCH_W      18
`define PDC_REF_RATIO_W      14
`define PDC_MAIN_RATIO_W     11
`define PDC_SWALLOW_W        7
`define PDC_FRAME_SEL_POS    0
`define PDC_REF_RATIO_LSB    0
`define PDC_REF_PRESC_POS    14
`define PDC_REF_POL_POS      15
`define PDC_REF_MON_POS      16
`define PDC_DIV_SWALLOW_LSB  0
`define PDC_DIV_MAIN_LSB     7

`define PDC_REF_LATCH_RST    17'h00005
`define PDC_DIV_LATCH_RST    18'h00280

`define PDC_OFS_FRAME        12'h000
`define PDC_OFS_STATUS       12'h004
`define PDC_OFS_REF_LATCH    12'h008
`define PDC_OFS_DIV_LATCH    12'h00c

`endif

// ==== pdc_div_if.sv ====
// link between the control logic and one programmable divider
`timescale 1ns/1ps
interface pdc_div_if #(parameter int WIDTH = 14);
   logic             tick;
   logic             clear;
   logic [WIDTH-1:0] ratio;
   logic             pulse;
   logic             half;

   modport ctrl (output tick, output clear, output ratio, input pulse, input half);
   modport div  (input tick, input clear, input ratio, output pulse, output half);
endinterface

// ==== pdc_divider.sv ====
// programmable divide-by-ratio counter with terminal pulse and half-rate square output
`timescale 1ns/1ps
module pdc_divider #(
   parameter int WIDTH = 14
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   pdc_div_if.div   port
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic             pulse;
      logic             half;
   } pdc_div_state_type;

   pdc_div_state_type st_r;
   pdc_div_state_type st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.pulse = 1'b0;
      if (port.clear) begin
         st_nxt = '0;
      end else if (port.tick) begin
         // terminal count at ratio-1 gives exactly ratio ticks per output pulse
         if (st_r.count >= port.ratio - WIDTH'(1)) begin
            st_nxt.count = '0;
            st_nxt.pulse = 1'b1;
            st_nxt.half  = ~st_r.half;
         end else begin
            st_nxt.count = st_r.count + WIDTH'(1);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign port.pulse = st_r.pulse;
   assign port.half  = st_r.half;
endmodule

// ==== pdc_host_model.sv ====
// serial host model driving the synthesizer programming pins
`timescale 1ns/1ps
module pdc_host_model (
   input  wire logic ref_clk,
   output logic      serData,
   output logic      serClk,
   output logic      loadStrobe
);
   initial begin
      serData = 1'b0;
      serClk = 1'b0;
      loadStrobe = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // bit 0 leaves first; clock stands low between frames
   task automatic send(input logic [18:0] w, input int nBits);
      for (int i = 0; i < nBits; i++) begin
         serData <= w[i];
         hold(4);
         serClk <= 1'b1;
         hold(4);
         serClk <= 1'b0;
      end
      hold(4);
      // data released: show the inverse so a stale bit cannot pass
      serData <= ~w[nBits-1];
      loadStrobe <= 1'b1;
      hold(4);
      loadStrobe <= 1'b0;
      hold(8);
   endtask
endmodule

// ==== pdc_pkg.sv ====
// types shared by the synthesizer control modules
package pdc_pkg;
   typedef enum logic [1:0] {
      PDC_SLEEP,
      PDC_WARM,
      PDC_RUN
   } pdc_power_type;

   typedef struct packed {
      logic        ok;
      logic [18:0] frame;
   } pdc_frame_type;
endpackage

// ==== pdc_pll_ctrl.sv ====
// serially programmed synthesizer control: latches, dividers, phase detector, power saving, register slave
// Operation
// - main counter is an 11-bit binary field, ratios 5 to 2047, never below 5; the code does not check this and loads any 11-bit value
// - swallow counter is a 7-bit binary field covering 0 to 127
// - prescaler select high gives 64/65, low gives 128/129
// - monitor select high shows divided monitor, low shows lock detect on shared pin
// - polarity bit inverts pump sense and both comparator outputs
// - polarity high: ref fast pump high; ref slow pump low; equal pump off
// - polarity low: ref fast pump low; ref slow pump high; equal pump off
// - monitor shows divided reference when polarity high, divided comparison when low
// - power-save pin low stops the loop logic; high returns to normal
// - after wake-up the phase error output is limited in length
// - in power saving the pump floats and lock detect reads locked
// - serial port keeps shifting and latching during power saving
// - pump-disable pin low floats the pump, high allows normal output
// - one data bit shifted in on each rising serial clock edge
// - load strobe rising moves word to reference latch if select high, else divider latch
// - divider word: select bit, swallow bits 1-7, main bits 1-11
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "pdc_consts.svh"
module pdc_pll_ctrl
   import pdc_pkg::*;
#(
   parameter int WAKE_CYCLES = `PDC_WAKE_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        serData,
   input  wire logic        serClk,
   input  wire logic        loadStrobe,
   input  wire logic        powerSavePin,
   input  wire logic        pumpDisablePin,
   input  wire logic        oscPin,
   input  wire logic        prescPin,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             prescalerRatioSelect,
   output logic             modulusCtrl,
   output logic             pumpOut,
   output logic             pumpOe,
   output logic             refPhaseOut,
   output logic             cmpPhaseOut,
   output logic             cmpPhaseOe,
   output logic             lockOrMonitorOut
);
   typedef struct packed {
      pdc_power_type                  power;
      logic [15:0]                    wakeCnt;
      logic [`PDC_FRAME_W-1:0]        shift;
      logic [4:0]                     bitCnt;
      logic                           serClkPrev;
      logic                           loadPrev;
      logic                           oscPrev;
      logic                           prescPrev;
      logic [`PDC_REF_LATCH_W-1:0]    refLatch;
      logic [`PDC_DIV_LATCH_W-1:0]    divLatch;
      logic [`PDC_SWALLOW_W-1:0]      swallowCnt;
      logic                           up;
      logic                           down;
      logic [7:0]                     errCnt;
      logic                           errLong;
      logic [7:0]                     lockCnt;
      logic                           lockDetect;
      logic                           pumpOut;
      logic                           pumpOe;
      logic                           refPhase;
      logic                           cmpPhaseOe;
      logic                           monOut;
      logic [31:0]                    prdata;
      logic                           pslverr;
   } pdc_ctrl_state_type;

   pdc_ctrl_state_type st_r;
   pdc_ctrl_state_type st_nxt;
   logic [6:0] pinSync;
   logic       dataS;
   logic       clkS;
   logic       loadS;
   logic       pwrS;
   logic       pumpEnS;
   logic       oscS;
   logic       prescS;

   pdc_sync #(.WIDTH(7)) u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pinIn   ({serData, serClk, loadStrobe, powerSavePin, pumpDisablePin, oscPin, prescPin}),
      .pinOut  (pinSync)
   );
   assign {dataS, clkS, loadS, pwrS, pumpEnS, oscS, prescS} = pinSync;
   pdc_div_if #(.WIDTH(`PDC_REF_RATIO_W))  refDiv ();
   pdc_div_if #(.WIDTH(`PDC_MAIN_RATIO_W)) mainDiv ();
   pdc_divider #(.WIDTH(`PDC_REF_RATIO_W)) u_ref_div (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .port    (refDiv.div)
   );
   pdc_divider #(.WIDTH(`PDC_MAIN_RATIO_W)) u_main_div (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .port    (mainDiv.div)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // latch fields
   logic [`PDC_REF_RATIO_W-1:0]  refRatio;
   logic [`PDC_MAIN_RATIO_W-1:0] mainRatio;
   logic [`PDC_SWALLOW_W-1:0]    swallowRatio;
   logic                         prescalerRatioSel;
   logic                         phasePolarityBit;
   logic                         monitorOutputSelect;
   logic                         sleeping;
   logic                         warming;

   assign refRatio            = st_r.refLatch[`PDC_REF_RATIO_LSB +: `PDC_REF_RATIO_W];
   assign prescalerRatioSel   = st_r.refLatch[`PDC_REF_PRESC_POS];
   assign phasePolarityBit    = st_r.refLatch[`PDC_REF_POL_POS];
   assign monitorOutputSelect = st_r.refLatch[`PDC_REF_MON_POS];
   assign mainRatio           = st_r.divLatch[`PDC_DIV_MAIN_LSB +: `PDC_MAIN_RATIO_W];
   assign swallowRatio        = st_r.divLatch[`PDC_DIV_SWALLOW_LSB +: `PDC_SWALLOW_W];
   assign sleeping            = (st_r.power == PDC_SLEEP);
   assign warming             = (st_r.power == PDC_WARM);
   // both dividers held cleared while asleep so they restart in step on wake-up
   assign refDiv.tick   = oscS & ~st_r.oscPrev;
   assign refDiv.clear  = sleeping;
   assign refDiv.ratio  = refRatio;
   assign mainDiv.tick  = prescS & ~st_r.prescPrev;
   assign mainDiv.clear = sleeping;
   assign mainDiv.ratio = mainRatio;

   ////////////////////////////////////////////////////////////////////////////////
   // frame handling shared by the serial port and the register slave
   // a word is complete at 18 bits (reference) or 19 or more bits (divider, count saturates at 19); anything else is partial
   function automatic pdc_frame_type alignFrame(input logic [`PDC_FRAME_W-1:0] sr, input logic [4:0] cnt);
      pdc_frame_type f;
      f.ok    = 1'b0;
      f.frame = sr;
      if (cnt >= `PDC_DIV_FRAME_BITS) begin
         f.ok = ~sr[`PDC_FRAME_SEL_POS];
      end else if (cnt == `PDC_REF_FRAME_BITS) begin
         f.frame = {1'b0, sr[`PDC_FRAME_W-1:1]};
         f.ok    = f.frame[`PDC_FRAME_SEL_POS];
      end
      return f;
   endfunction
   function automatic pdc_ctrl_state_type applyFrame(input pdc_ctrl_state_type s, input logic [`PDC_FRAME_W-1:0] wd);
      pdc_ctrl_state_type r;
      r = s;
      if (wd[`PDC_FRAME_SEL_POS]) begin
         r.refLatch = wd[`PDC_REF_LATCH_W:1];
      end else begin
         r.divLatch = wd[`PDC_DIV_LATCH_W:1];
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // register slave
   logic          apbAccess;
   logic          apbWrite;
   logic          apbRead;
   pdc_frame_type serFrame;
   logic          leadErr;
   logic          lagErr;
   logic          refPulseEvt;
   logic          cmpPulseEvt;

   assign apbAccess = psel & penable;
   assign apbWrite  = apbAccess & pwrite;
   assign apbRead   = apbAccess & ~pwrite;
   assign serFrame  = alignFrame(st_r.shift, st_r.bitCnt);

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.serClkPrev = clkS;
      st_nxt.loadPrev   = loadS;
      st_nxt.oscPrev    = oscS;
      st_nxt.prescPrev  = prescS;
      refPulseEvt = refDiv.pulse;
      cmpPulseEvt = mainDiv.pulse;
      // serial port runs regardless of the power state
      if (clkS && !st_r.serClkPrev) begin
         st_nxt.shift = {dataS, st_r.shift[`PDC_FRAME_W-1:1]};
         if (st_r.bitCnt < `PDC_DIV_FRAME_BITS) begin
            st_nxt.bitCnt = st_r.bitCnt + 5'h01;
         end
      end
      if (loadS && !st_r.loadPrev) begin
         if (serFrame.ok) begin
            st_nxt = applyFrame(st_nxt, serFrame.frame);
         end
         st_nxt.bitCnt = '0;
      end
      // a register write of a whole frame acts like a serial load and wins a same-cycle tie
      if (apbWrite && paddr == `PDC_OFS_FRAME) begin
         st_nxt = applyFrame(st_nxt, pwdata[`PDC_FRAME_W-1:0]);
      end
      // power state
      case (st_r.power)
         PDC_SLEEP: begin
            if (pwrS) begin
               st_nxt.power   = PDC_WARM;
               st_nxt.wakeCnt = 16'(WAKE_CYCLES);
            end
         end
         PDC_WARM: begin
            if (!pwrS) begin
               st_nxt.power = PDC_SLEEP;
            end else if (st_r.wakeCnt == '0) begin
               st_nxt.power = PDC_RUN;
            end else begin
               st_nxt.wakeCnt = st_r.wakeCnt - 16'h0001;
            end
         end
         PDC_RUN: begin
            if (!pwrS) begin
               st_nxt.power = PDC_SLEEP;
            end
         end
         default: begin
            st_nxt.power = PDC_SLEEP;
         end
      endcase

      // swallow counter: first A prescaler periods of each main cycle use the larger modulus
      if (sleeping || cmpPulseEvt) begin
         st_nxt.swallowCnt = swallowRatio;
      end else if (mainDiv.tick && st_r.swallowCnt != '0) begin
         st_nxt.swallowCnt = st_r.swallowCnt - 7'h01;
      end

      // phase-frequency detector: up means reference ahead of comparison
      if (sleeping) begin
         st_nxt.up         = 1'b0;
         st_nxt.down       = 1'b0;
         st_nxt.errCnt     = '0;
         st_nxt.errLong    = 1'b0;
         st_nxt.lockCnt    = '0;
         st_nxt.lockDetect = 1'b1;
      end else begin
         st_nxt.up   = st_r.up | refPulseEvt;
         st_nxt.down = st_r.down | cmpPulseEvt;
         if (st_nxt.up && st_nxt.down) begin
            st_nxt.up   = 1'b0;
            st_nxt.down = 1'b0;
         end
         if (st_r.up || st_r.down) begin
            if (st_r.errCnt != 8'hff) begin
               st_nxt.errCnt = st_r.errCnt + 8'h01;
            end
            if (st_r.errCnt >= `PDC_LOCK_WIN) begin
               st_nxt.errLong = 1'b1;
            end
            // right after wake-up an error pulse is cut short so an arbitrary start phase cannot kick the loop
            if (warming && st_r.errCnt >= `PDC_ERR_LIMIT - 8'h01) begin
               st_nxt.up   = 1'b0;
               st_nxt.down = 1'b0;
            end
         end else begin
            st_nxt.errCnt = '0;
         end
         // lock is judged once per reference period
         if (refPulseEvt) begin
            st_nxt.errLong = 1'b0;
            if (st_r.errLong) begin
               st_nxt.lockCnt    = '0;
               st_nxt.lockDetect = 1'b0;
            end else if (st_r.lockCnt >= `PDC_LOCK_COUNT - 8'h01) begin
               st_nxt.lockDetect = 1'b1;
            end else begin
               st_nxt.lockCnt = st_r.lockCnt + 8'h01;
            end
         end
      end

      // output stage: lead is the error that drives the pump high for the chosen polarity
      leadErr = phasePolarityBit ? st_r.up : st_r.down;
      lagErr  = phasePolarityBit ? st_r.down : st_r.up;
      if (leadErr) begin
         st_nxt.pumpOut    = 1'b1;
         st_nxt.refPhase   = 1'b0;
         st_nxt.cmpPhaseOe = 1'b1;
      end else if (lagErr) begin
         st_nxt.pumpOut    = 1'b0;
         st_nxt.refPhase   = 1'b1;
         st_nxt.cmpPhaseOe = 1'b0;
      end else begin
         st_nxt.pumpOut    = 1'b0;
         st_nxt.refPhase   = 1'b0;
         st_nxt.cmpPhaseOe = 1'b0;
      end
      st_nxt.pumpOe = (leadErr | lagErr) & pumpEnS & ~sleeping;
      if (sleeping) begin
         st_nxt.refPhase   = 1'b0;
         st_nxt.cmpPhaseOe = 1'b0;
      end
      if (monitorOutputSelect) begin
         st_nxt.monOut = phasePolarityBit ? refDiv.half : mainDiv.half;
      end else begin
         st_nxt.monOut = st_nxt.lockDetect;
      end

      // register reads answer in the access cycle; unmapped offsets flag an error
      st_nxt.prdata  = '0;
      st_nxt.pslverr = 1'b0;
      if (psel && !penable) begin
         case (paddr)
            `PDC_OFS_FRAME: begin
               st_nxt.prdata = '0;
            end
            `PDC_OFS_STATUS: begin
               st_nxt.prdata = {24'h000000, st_r.errLong, st_r.down, st_r.up, modulusCtrl,
                                pwrS, st_r.power, st_r.lockDetect};
            end
            `PDC_OFS_REF_LATCH: begin
               st_nxt.prdata = {15'h0000, st_r.refLatch};
            end
            `PDC_OFS_DIV_LATCH: begin
               st_nxt.prdata = {14'h0000, st_r.divLatch};
            end
            default: begin
               st_nxt.pslverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r            <= '0;
         st_r.power      <= PDC_SLEEP;
         st_r.refLatch   <= `PDC_REF_LATCH_RST;
         st_r.divLatch   <= `PDC_DIV_LATCH_RST;
         st_r.lockDetect <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign prescalerRatioSelect = prescalerRatioSel;
   assign modulusCtrl          = (st_r.swallowCnt != '0);
   assign pumpOut              = st_r.pumpOut;
   assign pumpOe               = st_r.pumpOe;
   assign refPhaseOut          = st_r.refPhase;
   assign cmpPhaseOut          = 1'b0;
   assign cmpPhaseOe           = st_r.cmpPhaseOe;
   assign lockOrMonitorOut     = st_r.monOut;
   assign pready               = 1'b1;
   assign prdata               = apbRead ? st_r.prdata : 32'h00000000;
   assign pslverr              = apbAccess & st_r.pslverr;
endmodule

// ==== pdc_pll_ctrl_bench.sv ====
// self-checking bench for the synthesizer control block
`timescale 1ns/1ps
`include "pdc_consts.svh"
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin numErrors++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module pdc_pll_ctrl_bench
   import pdc_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        powerSavePin = 1'b0;
   logic        pumpDisablePin = 1'b1;
   logic        oscPin = 1'b0;
   logic        prescPin = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdv;
   logic        pready, pslverr, errv, serData, serClk, loadStrobe, presc, pumpOut, pumpOe, modCtrl;
   logic        refPhaseOut, cmpPhaseOut, cmpPhaseOe, lockOrMonitorOut, sawPump = 1'b0;
   int          numErrors = 0;
   int          samplesChecked = 0;
   int          tick = 0;
   logic [17:0] divTab [3] = '{{11'h7ff, 7'h7f}, {11'h005, 7'h00}, {11'h006, 7'h01}};
   always #5 ref_clk = ~ref_clk;
   // unequal rates keep the comparator busy
   always @(posedge ref_clk) begin
      tick <= tick + 1;
      oscPin <= (tick % 6) < 3;
      prescPin <= (tick % 4) < 2;
      if (pumpOe === 1'b1) sawPump <= 1'b1;
   end
   pdc_host_model host (.ref_clk(ref_clk), .serData(serData), .serClk(serClk), .loadStrobe(loadStrobe));
   // warm-up long enough that the first error pulses after wake fall inside it
   pdc_pll_ctrl #(.WAKE_CYCLES(60)) uut (
      .ref_clk(ref_clk), .rst_n(rst_n), .serData(serData), .serClk(serClk), .loadStrobe(loadStrobe),
      .powerSavePin(powerSavePin), .pumpDisablePin(pumpDisablePin), .oscPin(oscPin), .prescPin(prescPin),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .prescalerRatioSelect(presc), .modulusCtrl(modCtrl),
      .pumpOut(pumpOut), .pumpOe(pumpOe), .refPhaseOut(refPhaseOut), .cmpPhaseOut(cmpPhaseOut),
      .cmpPhaseOe(cmpPhaseOe), .lockOrMonitorOut(lockOrMonitorOut)
   );
   ////////////////////////////////////////
   task automatic giveVerdict;
      $display("checks %0d errors %0d", samplesChecked, numErrors);
      if (numErrors == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         numErrors++;
         giveVerdict();
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   // cycles between two changes of the shared output
   task automatic gapOf(output int g);
      logic v;
      int n;
      v = lockOrMonitorOut;
      for (n = 0; n < 200 && lockOrMonitorOut === v; n++) @(posedge ref_clk);
      v = lockOrMonitorOut;
      for (g = 0; g < 200 && lockOrMonitorOut === v; g++) @(posedge ref_clk);
   endtask
   ////////////////////////////////////////
   initial begin
      int n, g;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rd(`PDC_OFS_REF_LATCH);
      `CHK(rdv[16:0], `PDC_REF_LATCH_RST)
      rd(`PDC_OFS_DIV_LATCH);
      `CHK(rdv[17:0], `PDC_DIV_LATCH_RST)
      rd(12'h010);
      `CHK(errv, 1'b1)
      apb(1'b1, 12'h010, 32'hffffffff);
      `CHK(errv, 1'b1)
      rd(`PDC_OFS_STATUS);
      `CHK(rdv[2:1], PDC_SLEEP)
      $display("test reset done");
      foreach (divTab[i]) begin
         host.send({divTab[i], 1'b0}, 19);
         rd(`PDC_OFS_DIV_LATCH);
         `CHK(rdv[17:0], divTab[i])
         `CHK(modCtrl, divTab[i][6:0] != 7'h00)
      end
      host.send(19'h7fffe, 10);
      host.send(19'h00003, 12);
      rd(`PDC_OFS_DIV_LATCH);
      `CHK(rdv[17:0], divTab[2])
      rd(`PDC_OFS_REF_LATCH);
      `CHK(rdv[16:0], `PDC_REF_LATCH_RST)
      $display("test divider words done");
      host.send({1'b0, 1'b0, 1'b0, 14'h3fff, 1'b1}, 18);
      `CHK(presc, 1'b0)
      host.send({1'b0, 1'b1, 1'b1, 14'h0005, 1'b1}, 18);
      `CHK(presc, 1'b1)
      rd(`PDC_OFS_REF_LATCH);
      `CHK(rdv[16:0], 17'h0c005)
      $display("test reference words done");
      repeat (100) @(posedge ref_clk);
      powerSavePin <= 1'b1;
      for (n = 0; n < 50; n++) begin
         rd(`PDC_OFS_STATUS);
         if (rdv[2:1] === PDC_RUN) break;
      end
      `CHK(rdv[2:1], PDC_RUN)
      repeat (300) @(posedge ref_clk);
      `CHK(sawPump, 1'b1)
      pumpDisablePin <= 1'b0;
      repeat (6) @(posedge ref_clk);
      for (n = 0; n < 40; n++) begin
         @(posedge ref_clk);
         `CHK(pumpOe, 1'b0)
      end
      pumpDisablePin <= 1'b1;
      $display("test wake and pump done");
      host.send({1'b1, 1'b1, 1'b1, 14'h0005, 1'b1}, 18);
      gapOf(g);
      `CHK(g < 60, 1'b1)
      `CHK(g > 27, 1'b1)
      host.send({1'b1, 1'b0, 1'b1, 14'h0005, 1'b1}, 18);
      gapOf(g);
      `CHK(g < 60, 1'b1)
      `CHK(g > 27, 1'b0)
      host.send({1'b0, 1'b1, 1'b1, 14'h0005, 1'b1}, 18);
      powerSavePin <= 1'b0;
      repeat (10) @(posedge ref_clk);
      `CHK(pumpOe, 1'b0)
      `CHK(lockOrMonitorOut, 1'b1)
      rd(`PDC_OFS_STATUS);
      `CHK(rdv[0], 1'b1)
      $display("test monitor and sleep done");
      giveVerdict();
   end
endmodule

// ==== pdc_pll_ctrl_properties.sv ====
// port-level checks of the synthesizer control block
`timescale 1ns/1ps
module pdc_pll_ctrl_properties #(
   parameter int WAKE_CYCLES = 200
) (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        loadStrobe,
   input wire logic        powerSavePin,
   input wire logic        pumpDisablePin,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        prescalerRatioSelect,
   input wire logic        pumpOut,
   input wire logic        pumpOe,
   input wire logic        refPhaseOut,
   input wire logic        cmpPhaseOut,
   input wire logic        cmpPhaseOe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   logic [15:0] wakeCnt_r;
   logic [3:0]  onCnt_r;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wakeCnt_r <= 16'h0000;
         onCnt_r <= 4'h0;
      end else begin
         wakeCnt_r <= !powerSavePin ? 16'h0000 : wakeCnt_r + {15'h0000, wakeCnt_r != 16'hffff};
         onCnt_r <= !pumpOe ? 4'h0 : onCnt_r + {3'h0, onCnt_r != 4'hf};
      end
   end
   ////////////////////////////////////////
   // pin levels pass a synchronizer, so allow six edges
   sequence sleepLong;
      !powerSavePin [*6];
   endsequence
   sequence noUpdate;
      (!loadStrobe && !(psel && penable && pwrite)) [*6];
   endsequence
   AST_UNMAPPED_ERR: assert property (psel && penable && paddr > 12'h00c |-> pslverr)
      else $error("unmapped access without error");
   AST_IDLE_QUIET: assert property (!(psel && penable) |-> !pslverr && prdata == 32'h0)
      else $error("bus outputs active outside access");
   AST_CMP_DRAIN: assert property (cmpPhaseOut == 1'b0)
      else $error("open drain output driven high");
   AST_CMP_EXCL: assert property (refPhaseOut |-> !cmpPhaseOe)
      else $error("both comparator outputs active");
   AST_PUMP_SENSE: assert property (pumpOe |-> pumpOut == cmpPhaseOe && refPhaseOut == !pumpOut)
      else $error("pump sense disagrees with comparator");
   AST_EQUAL_FLOAT: assert property (!refPhaseOut && !cmpPhaseOe |-> !pumpOe)
      else $error("pump driven with no phase error");
   AST_SLEEP_FLOAT: assert property (sleepLong |-> !pumpOe)
      else $error("pump driven while asleep");
   AST_DISABLE_FLOAT: assert property (!pumpDisablePin [*6] |-> !pumpOe)
      else $error("pump driven while disabled");
   AST_HOLD_SETTINGS: assert property (noUpdate |=> $stable(prescalerRatioSelect))
      else $error("setting changed without a load");
   AST_WARM_LIMIT: assert property (powerSavePin && wakeCnt_r < WAKE_CYCLES |-> onCnt_r <= 4'h4)
      else $error("long error pulse during wake up");
endmodule
bind pdc_pll_ctrl pdc_pll_ctrl_properties #(.WAKE_CYCLES(WAKE_CYCLES)) chk (
   .ref_clk, .rst_n, .loadStrobe, .powerSavePin, .pumpDisablePin, .psel, .penable, .pwrite, .paddr,
   .prdata, .pslverr, .prescalerRatioSelect, .pumpOut, .pumpOe, .refPhaseOut, .cmpPhaseOut, .cmpPhaseOe
);

// ==== pdc_sync.sv ====
// two-stage synchronizer for pin inputs
`timescale 1ns/1ps
module pdc_sync #(
   parameter int WIDTH = 7
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] pinOut
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } pdc_sync_state_type;

   pdc_sync_state_type st_r;
   pdc_sync_state_type st_nxt;

   always_comb begin
      st_nxt.stage1 = pinIn;
      st_nxt.stage2 = st_r.stage1;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pinOut = st_r.stage2;
endmodule
